// >>> hdl/spd_consts.vh
// Constants for the strobe phase shift delay loop block
// Function
// - io cell registers convert full-rate and half-rate data, write and read
// - Rate conversion registers can be bypassed for a full-rate controller
// - Incoming read strobes get a phase shift before data capture; the code caps the shift to zero cycles at this clock
// - Each strobe picks one of two loop output settings
// - All strobe pins load a new delay setting at the same instant
// - Delay setting is Gray coded, one bit changes per update
// - Lock within 1280 cycles in low-jitter mode, else 256
// - Below 100 MHz strobe shift is limited to 2.5 ns
// - At most four loops, one per corner, one frequency each
// - Each loop has two outputs with different phase offsets
// - Each loop reaches only the two sides next to its corner
// - Strobe groups choose either adjacent loop per group
// - One leveling chain per sub-bank, one leveling interface there
// - Loop reference selectable from PLL outputs or dedicated clock pins
// - Phase comparator up/down steps Gray counter of six-bit setting
// - Loop reset from fabric or pin; relock 1280 cycles after reset in low-jitter mode, else 256
// - Strobe shift from fixed phase set, 22.5 to 240 degrees; the code shifts by whole clock cycles, capped to zero here
`ifndef SPD_CONSTS_VH
`define SPD_CONSTS_VH
`define SPD_CLK_MHZ 40
`define SPD_CLK_PERIOD_PS 25000
`define SPD_SET_W 6
`define SPD_LOOPS 4
`define SPD_GROUPS 8
`define SPD_LOCK_LJ_CYC 1280
`define SPD_LOCK_FAST_CYC 256
`define SPD_LOCK_W 11
`define SPD_LOW_FREQ_MHZ 100
`define SPD_MAX_SHIFT_PS 2500
`define SPD_MAX_SHIFT_CYC ((`SPD_MAX_SHIFT_PS) / (`SPD_CLK_PERIOD_PS))
`define SPD_CHAIN_MAX 6'h10
`define SPD_SET_RST 6'h00
`define SPD_NUM_PHASES 15
`define SPD_DATA_W 8
`endif

// >>> hdl/spd_corner_loop.v
// One corner delay loop with Gray coded setting, lock counter and two offset outputs
`timescale 1ns/10ps
`default_nettype none
`include "spd_consts.vh"
module spd_corner_loop (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire loop_rst,
	// Control
	input wire low_jitter,
	input wire [3:0] ref_sel,
	input wire [15:0] ref_in,
	input wire [5:0] offset_a,
	input wire [5:0] offset_b,
	// Status and settings
	output reg locked,
	output reg [5:0] gray_set,
	output reg [5:0] set_a,
	output reg [5:0] set_b,
	output reg update
);
	reg [5:0] bin_set;
	reg [10:0] lock_cnt;
	reg ref_q1;
	reg ref_q2;
	reg ref_q3;
	reg [4:0] chain_cnt;
	reg [4:0] period_cnt;
	wire [10:0] lock_lim;
	wire ref_bit;
	wire ref_edge;
	wire up;
	wire dn;
	wire [5:0] next_bin;
	wire [5:0] next_gray;
	wire [5:0] sum_a;
	wire [5:0] sum_b;

	assign ref_bit = ref_in[ref_sel];
	assign ref_edge = ref_q2 & ~ref_q3;
	assign lock_lim = low_jitter ? 11'd`SPD_LOCK_LJ_CYC : 11'd`SPD_LOCK_FAST_CYC;
	// Delay chain length follows the upper four setting bits, at most fifteen elements
	assign up = ref_edge && (period_cnt > chain_cnt) && (bin_set != 6'h3F);
	assign dn = ref_edge && (period_cnt < chain_cnt) && (bin_set != 6'h00);
	assign next_bin = up ? bin_set + 6'h01 : (dn ? bin_set - 6'h01 : bin_set);
	assign next_gray = next_bin ^ {1'b0, next_bin[5:1]};
	// Offset sums wrap modulo 64, so a tracker step stays a one-bit Gray step
	assign sum_a = next_bin + offset_a;
	assign sum_b = next_bin + offset_b;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_q1 <= 1'b0;
			ref_q2 <= 1'b0;
			ref_q3 <= 1'b0;
			bin_set <= `SPD_SET_RST;
			gray_set <= `SPD_SET_RST;
			lock_cnt <= 11'h000;
			locked <= 1'b0;
			chain_cnt <= 5'h00;
			period_cnt <= 5'h00;
			set_a <= 6'h00;
			set_b <= 6'h00;
			update <= 1'b0;
		end else if (ce) begin
			ref_q1 <= ref_bit;
			ref_q2 <= ref_q1;
			ref_q3 <= ref_q2;
			if (loop_rst) begin
				bin_set <= `SPD_SET_RST;
				gray_set <= `SPD_SET_RST;
				lock_cnt <= 11'h000;
				locked <= 1'b0;
				period_cnt <= 5'h00;
				update <= 1'b0;
			end else begin
				chain_cnt <= (bin_set[5:2] > 4'hF) ? 5'h10 : {1'b0, bin_set[5:2]};
				if (ref_edge)
					period_cnt <= 5'h00;
				else if (period_cnt != 5'h1F)
					period_cnt <= period_cnt + 5'h01;
				bin_set <= next_bin;
				gray_set <= next_gray;
				if (!locked) begin
					lock_cnt <= lock_cnt + 11'h001;
					if (lock_cnt + 11'h001 >= lock_lim)
						locked <= 1'b1;
				end
				// Offsets applied to the binary value, Gray recoded for the strobes
				set_a <= sum_a ^ {1'b0, sum_a[5:1]};
				set_b <= sum_b ^ {1'b0, sum_b[5:1]};
				update <= (next_gray != gray_set);
			end
		end
	end
endmodule // spd_corner_loop
`default_nettype wire

// >>> hdl/spd_top.v
// Strobe phase shift top: four corner loops, strobe routing, rate conversion, Wishbone registers
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "spd_consts.vh"
module spd_top (
	// Clock and reset
	input wire REF_CLK,
	input wire RST_N,
	input wire CE,
	// Wishbone slave
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output reg [31:0] WB_DAT_O,
	output wire WB_ACK_O,
	// Loop reset pin and reference candidates
	input wire LOOP_RST_PIN,
	input wire [15:0] REF_SRC,
	// Strobe groups
	input wire [7:0] STROBE_IN,
	output reg [7:0] STROBE_SHIFTED,
	output reg [47:0] GROUP_SETTING,
	output reg GROUP_UPDATE,
	// Leveling chain per sub-bank
	output reg [47:0] LEVEL_SETTING,
	// Rate conversion, write direction
	input wire [15:0] CTRL_WR_DATA,
	output reg [7:0] IO_WR_DATA,
	// Rate conversion, read direction
	input wire [7:0] IO_RD_DATA,
	output reg [15:0] CTRL_RD_DATA,
	output reg RD_VALID
);
	localparam ADR_CTRL = 8'h00;
	localparam ADR_STAT = 8'h04;
	localparam ADR_SEL = 8'h08;
	localparam ADR_OFS = 8'h0C;
	localparam ADR_REFSEL = 8'h10;
	localparam ADR_PHASE = 8'h14;
	localparam ADR_LEVEL = 8'h18;
	localparam ADR_SET = 8'h1C;

	reg [31:0] ctrl;
	reg [31:0] grp_sel;
	reg [31:0] ofs;
	reg [15:0] ref_sel;
	reg [31:0] phase_sel;
	reg [15:0] lvl_sel;
	reg ack;
	reg pin_q1;
	reg pin_q2;
	reg [7:0] stb_q1;
	reg [7:0] stb_q2;
	reg [7:0] rd_q1;
	reg [7:0] rd_q2;
	reg half;
	reg [7:0] rd_lo;
	reg [7:0] stb_hist [0:7];
	wire [3:0] locked;
	wire [23:0] gray;
	wire [23:0] set_a;
	wire [23:0] set_b;
	wire [3:0] upd;
	wire bypass;
	wire wr;
	integer g;
	integer s;
	reg [23:0] shift_cyc;
	wire [31:0] max_shift;

	assign max_shift = `SPD_MAX_SHIFT_CYC;

	assign bypass = ctrl[8];
	assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~ack;
	assign WB_ACK_O = ack;

	genvar k;
	generate
		for (k = 0; k < `SPD_LOOPS; k = k + 1) begin : g_loop
			spd_corner_loop u_loop (
				.clk(REF_CLK),
				.rst_n(RST_N),
				.ce(CE),
				.loop_rst(ctrl[k] | pin_q2),
				.low_jitter(ctrl[4 + k]),
				.ref_sel(ref_sel[4 * k +: 4]),
				.ref_in(REF_SRC),
				.offset_a(ofs[8 * k +: 6]),
				.offset_b(ofs[8 * k + 6 +: 2] == 2'b00 ? 6'h20 : {ofs[8 * k + 6 +: 2], 4'h0}),
				.locked(locked[k]),
				.gray_set(gray[6 * k +: 6]),
				.set_a(set_a[6 * k +: 6]),
				.set_b(set_b[6 * k +: 6]),
				.update(upd[k])
			);
		end
	endgenerate

	// Group g sits in side g/2; adjacent corners per side: left 0,1 bottom 1,2 right 2,3 top 3,0
	function [1:0] spd_corner;
		input [2:0] grp;
		input pick;
		reg [1:0] side;
		begin
			side = grp[2:1];
			spd_corner = pick ? side + 2'd1 : side;
		end
	endfunction

	// Wishbone slave, one wait-free cycle answer
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ack <= 1'b0;
			WB_DAT_O <= 32'h00000000;
			ctrl <= 32'h000000F0;
			grp_sel <= 32'h00000000;
			ofs <= 32'h00000000;
			ref_sel <= 16'h0000;
			phase_sel <= 32'h00000000;
			lvl_sel <= 16'h0000;
		end else if (CE) begin
			ack <= WB_CYC_I & WB_STB_I & ~ack;
			if (ctrl[3:0] != 4'h0)
				ctrl[3:0] <= 4'h0;
			if (wr) begin
				case (WB_ADR_I)
					ADR_CTRL: begin
						if (WB_SEL_I[0])
							ctrl[7:0] <= WB_DAT_I[7:0];
						if (WB_SEL_I[1])
							ctrl[8] <= WB_DAT_I[8];
					end
					ADR_SEL: begin
						if (WB_SEL_I[0])
							grp_sel[7:0] <= WB_DAT_I[7:0];
						if (WB_SEL_I[1])
							grp_sel[15:8] <= WB_DAT_I[15:8];
					end
					ADR_OFS: begin
						if (WB_SEL_I[0])
							ofs[7:0] <= WB_DAT_I[7:0];
						if (WB_SEL_I[1])
							ofs[15:8] <= WB_DAT_I[15:8];
						if (WB_SEL_I[2])
							ofs[23:16] <= WB_DAT_I[23:16];
						if (WB_SEL_I[3])
							ofs[31:24] <= WB_DAT_I[31:24];
					end
					ADR_REFSEL: begin
						if (WB_SEL_I[0])
							ref_sel[7:0] <= WB_DAT_I[7:0];
						if (WB_SEL_I[1])
							ref_sel[15:8] <= WB_DAT_I[15:8];
					end
					ADR_PHASE: begin
						if (WB_SEL_I[0])
							phase_sel[7:0] <= WB_DAT_I[7:0];
						if (WB_SEL_I[1])
							phase_sel[15:8] <= WB_DAT_I[15:8];
						if (WB_SEL_I[2])
							phase_sel[23:16] <= WB_DAT_I[23:16];
						if (WB_SEL_I[3])
							phase_sel[31:24] <= WB_DAT_I[31:24];
					end
					ADR_LEVEL: begin
						if (WB_SEL_I[0])
							lvl_sel[7:0] <= WB_DAT_I[7:0];
						if (WB_SEL_I[1])
							lvl_sel[15:8] <= WB_DAT_I[15:8];
					end
					default: begin
					end
				endcase
			end
			case (WB_ADR_I)
				ADR_CTRL: WB_DAT_O <= {23'h000000, ctrl[8], ctrl[7:4], 4'h0};
				ADR_STAT: WB_DAT_O <= {28'h0000000, locked};
				ADR_SEL: WB_DAT_O <= {16'h0000, grp_sel[15:0]};
				ADR_OFS: WB_DAT_O <= ofs;
				ADR_REFSEL: WB_DAT_O <= {16'h0000, ref_sel};
				ADR_PHASE: WB_DAT_O <= phase_sel;
				ADR_LEVEL: WB_DAT_O <= {16'h0000, lvl_sel};
				ADR_SET: WB_DAT_O <= {8'h00, gray};
				default: WB_DAT_O <= 32'h00000000;
			endcase
		end
	end

	// Pin inputs pass two flops before use
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_q1 <= 1'b0;
			pin_q2 <= 1'b0;
			stb_q1 <= 8'h00;
			stb_q2 <= 8'h00;
			rd_q1 <= 8'h00;
			rd_q2 <= 8'h00;
		end else if (CE) begin
			pin_q1 <= LOOP_RST_PIN;
			pin_q2 <= pin_q1;
			stb_q1 <= STROBE_IN;
			stb_q2 <= stb_q1;
			rd_q1 <= IO_RD_DATA;
			rd_q2 <= rd_q1;
		end
	end

	// Requested shift per group; at this clock one cycle already exceeds the 2.5 ns cap
	always @* begin
		shift_cyc = 24'h000000;
		for (s = 0; s < `SPD_GROUPS; s = s + 1) begin
			if ({29'h00000000, phase_sel[4 * s +: 3]} > max_shift)
				shift_cyc[3 * s +: 3] = max_shift[2:0];
			else
				shift_cyc[3 * s +: 3] = phase_sel[4 * s +: 3];
		end
	end

	// Settings distribution: one shared update pulse loads every group together
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			GROUP_SETTING <= 48'h000000000000;
			GROUP_UPDATE <= 1'b0;
			LEVEL_SETTING <= 48'h000000000000;
			STROBE_SHIFTED <= 8'h00;
			for (g = 0; g < `SPD_GROUPS; g = g + 1)
				stb_hist[g] <= 8'h00;
		end else if (CE) begin
			GROUP_UPDATE <= |upd;
			for (g = 0; g < `SPD_GROUPS; g = g + 1) begin
				// Choose loop by group, then output A or B of that loop
				if (grp_sel[2 * g + 1])
					GROUP_SETTING[6 * g +: 6] <= set_b[6 * spd_corner(g[2:0], grp_sel[2 * g]) +: 6];
				else
					GROUP_SETTING[6 * g +: 6] <= set_a[6 * spd_corner(g[2:0], grp_sel[2 * g]) +: 6];
				// Leveling chain: one per sub-bank, one interface
				LEVEL_SETTING[6 * g +: 6] <= lvl_sel[2 * g + 1] ?
					gray[6 * spd_corner(g[2:0], lvl_sel[2 * g]) +: 6] : 6'h00;
				stb_hist[g] <= {stb_hist[g][6:0], stb_q2[g]};
				STROBE_SHIFTED[g] <= (shift_cyc[3 * g +: 3] == 3'h0) ? stb_q2[g] :
					stb_hist[g][shift_cyc[3 * g +: 3] - 3'h1];
			end
		end
	end

	// Half-rate conversion; bypass passes low word straight through
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			half <= 1'b0;
			rd_lo <= 8'h00;
			IO_WR_DATA <= 8'h00;
			CTRL_RD_DATA <= 16'h0000;
			RD_VALID <= 1'b0;
		end else if (CE) begin
			if (bypass) begin
				half <= 1'b0;
				IO_WR_DATA <= CTRL_WR_DATA[7:0];
				CTRL_RD_DATA <= {8'h00, rd_q2};
				RD_VALID <= 1'b1;
			end else begin
				half <= ~half;
				IO_WR_DATA <= half ? CTRL_WR_DATA[15:8] : CTRL_WR_DATA[7:0];
				if (!half)
					rd_lo <= rd_q2;
				else
					CTRL_RD_DATA <= {rd_q2, rd_lo};
				RD_VALID <= half;
			end
		end
	end
endmodule // spd_top
`default_nettype wire

// >>> tb/spd_top_sva.sv
// Port-level checker for the strobe phase shift top
`timescale 1ns/10ps
`default_nettype none
module spd_top_sva (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic CE,
	// Bus and loop reset
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	input wire logic LOOP_RST_PIN,
	// Strobe side
	input wire logic [7:0] STROBE_IN,
	input wire logic [7:0] STROBE_SHIFTED,
	input wire logic [47:0] GROUP_SETTING,
	input wire logic [47:0] LEVEL_SETTING,
	input wire logic GROUP_UPDATE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// Bus writes and loop resets make settings jump, so steps are judged only when quiet
	logic [2:0] quiet;
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N)
			quiet <= 3'h0;
		else if (WB_CYC_I || LOOP_RST_PIN)
			quiet <= 3'h0;
		else if (quiet != 3'h7)
			quiet <= quiet + 3'h1;
	end
	property p_ack_lat;
		WB_CYC_I && WB_STB_I && !WB_ACK_O && CE |=> WB_ACK_O;
	endproperty
	a_ack_lat: assert property (p_ack_lat) else $error("request not answered");
	property p_ack_pulse;
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_cause;
		WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I && CE);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_freeze;
		!CE |=> $stable(GROUP_SETTING) && $stable(STROBE_SHIFTED);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");
	property p_gray;
		quiet == 3'h7 |-> $onehot0(GROUP_SETTING[5:0] ^ $past(GROUP_SETTING[5:0]));
	endproperty
	a_gray: assert property (p_gray) else $error("setting step not one bit");
	property p_upd;
		quiet == 3'h7 && $changed(GROUP_SETTING) |->
			(GROUP_UPDATE || $past(GROUP_UPDATE)) or (##1 GROUP_UPDATE);
	endproperty
	a_upd: assert property (p_upd) else $error("setting changed without update");
	property p_strobe;
		STROBE_SHIFTED == $past(STROBE_IN, 2) || STROBE_SHIFTED == $past(STROBE_IN, 3);
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe shifted past cap");
	property p_rst_zero;
		$rose(RST_N) |-> GROUP_SETTING == 48'h0 && LEVEL_SETTING == 48'h0 && !WB_ACK_O;
	endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("outputs not clear");
	c_upd: cover property (GROUP_UPDATE);
	c_step: cover property (quiet == 3'h7 && $changed(GROUP_SETTING));
	c_freeze: cover property (!CE);
endmodule // spd_top_sva
bind spd_top spd_top_sva u_spd_top_sva (.REF_CLK(REF_CLK), .RST_N(RST_N), .CE(CE),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
	.LOOP_RST_PIN(LOOP_RST_PIN), .STROBE_IN(STROBE_IN), .STROBE_SHIFTED(STROBE_SHIFTED),
	.GROUP_SETTING(GROUP_SETTING), .LEVEL_SETTING(LEVEL_SETTING),
	.GROUP_UPDATE(GROUP_UPDATE));
`default_nettype wire

// >>> tb/spd_far_model.sv
// Far-side model: strobe logic sending read strobes and data
`timescale 1ns/10ps
`default_nettype none
module spd_far_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bench control
	input wire logic go,
	input wire logic [7:0] rd_byte,
	// Toward the design
	output logic [7:0] strobe,
	output logic [7:0] rd_data,
	// From the design
	input wire logic [47:0] setting,
	input wire logic upd,
	output logic [15:0] upd_count
);
	// Strobes and rd_byte are sent only while go is high; otherwise rd_data toggles each cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobe <= 8'h00;
			rd_data <= 8'h00;
		end else if (go) begin
			strobe <= strobe + 8'h01;
			rd_data <= rd_byte;
		end else
			rd_data <= ~rd_data;
	end
	// Updates are counted only while go is high and the setting is not zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			upd_count <= 16'h0000;
		else if (go && upd && setting != 48'h0)
			upd_count <= upd_count + 16'h0001;
	end
endmodule // spd_far_model
`default_nettype wire

// >>> tb/spd_top_test.sv
// Testbench for the strobe phase shift top
`timescale 1ns/10ps
`default_nettype none
module spd_top_test;
	logic ref_clk = 1'b0;
	logic rst_n, ce, cyc, stb, we, ack, pin, grp_upd, rd_valid, go;
	logic [7:0] adr, strobe_in, strobe_sh, wr_full, rd_full, a, b;
	logic [3:0] sel;
	logic [31:0] dat_i, dat_o, q, gs;
	logic [15:0] ref_src = 16'h00FF;
	logic [15:0] wr_half, rd_half, upd_count;
	logic [47:0] grp_set, lvl_set;
	logic [7:0] radr [4] = '{8'h08, 8'h0C, 8'h10, 8'h14};
	logic [31:0] rval [4] = '{32'h0000_AAAA, 32'hC382_1041, 32'h0000_3210, 32'h7654_3210};
	int err_count, checks;
	spd_top u_spd_top (.REF_CLK(ref_clk), .RST_N(rst_n), .CE(ce), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack), .LOOP_RST_PIN(pin), .REF_SRC(ref_src),
		.STROBE_IN(strobe_in), .STROBE_SHIFTED(strobe_sh), .GROUP_SETTING(grp_set),
		.GROUP_UPDATE(grp_upd), .LEVEL_SETTING(lvl_set), .CTRL_WR_DATA(wr_half),
		.IO_WR_DATA(wr_full), .IO_RD_DATA(rd_full), .CTRL_RD_DATA(rd_half),
		.RD_VALID(rd_valid));
	spd_far_model u_spd_far_model (.clk(ref_clk), .rst_n(rst_n), .go(go), .rd_byte(8'hA5),
		.strobe(strobe_in), .rd_data(rd_full), .setting(grp_set), .upd(grp_upd),
		.upd_count(upd_count));
	always #12.5 ref_clk = ~ref_clk;
	// Loop references keep moving so the trackers have work
	always @(posedge ref_clk) ref_src <= ~ref_src;
	task cmp(input string nm, input [31:0] exp, input [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic [5:0] b2g(input [5:0] x);
		b2g = x ^ {1'b0, x[5:1]};
	endfunction
	function automatic [5:0] g2b(input [5:0] x);
		g2b = x;
		for (int i = 4; i >= 0; i--)
			g2b[i] = g2b[i + 1] ^ x[i];
	endfunction
	task wb(input [7:0] ad, input w, input [31:0] d);
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		sel <= 4'hF;
		we <= w;
		adr <= ad;
		dat_i <= d;
		do @(posedge ref_clk); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge ref_clk);
	endtask
	task chk(input [7:0] ad, input [31:0] exp);
		wb(ad, 1'b0, 32'h0);
		cmp($sformatf("reg_%h", ad), exp, q);
	endtask
	task wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task print_verdict;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		wt(20000);
		err_count++;
		print_verdict;
	end
	initial begin
		{rst_n, cyc, stb, we, pin, go, err_count, checks} = '0;
		{ce, sel, adr, dat_i, wr_half} = {1'b1, 4'hF, 8'h00, 32'h0, 16'h3C5A};
		wt(12);
		rst_n <= 1'b1;
		chk(8'h00, 32'h0000_00F0);
		chk(8'h04, 32'h0);
		wb(8'hFC, 1'b1, 32'hFFFF_FFFF);
		chk(8'hFC, 32'h0);
		ce <= 1'b0;
		wt(5);
		ce <= 1'b1;
		wt(1230);
		chk(8'h04, 32'h0);
		wt(40);
		chk(8'h04, 32'hF);
		wb(8'h00, 1'b1, 32'h0000_000F);
		chk(8'h00, 32'h0);
		wt(230);
		chk(8'h04, 32'h0);
		wt(40);
		chk(8'h04, 32'hF);
		pin <= 1'b1;
		wt(4);
		pin <= 1'b0;
		wt(230);
		chk(8'h04, 32'h0);
		wt(40);
		chk(8'h04, 32'hF);
		go <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wb(radr[i], 1'b1, rval[i]);
			chk(radr[i], rval[i]);
		end
		wb(8'h1C, 1'b0, 32'h0);
		gs = q;
		cmp("grp0_b", {26'h0, b2g(g2b(gs[5:0]) + 6'h10)}, {26'h0, grp_set[5:0]});
		cmp("grp7_b", {26'h0, b2g(g2b(gs[23:18]) + 6'h30)}, {26'h0, grp_set[47:42]});
		wb(8'h08, 1'b1, 32'h0000_0001);
		wt(4);
		cmp("grp0_pick", {26'h0, b2g(g2b(gs[11:6]) + 6'h10)}, {26'h0, grp_set[5:0]});
		@(posedge ref_clk);
		cmp("strobe_sh", {24'h0, strobe_in - 8'h03}, {24'h0, strobe_sh});
		wb(8'h18, 1'b1, 32'h0000_0002);
		wt(4);
		cmp("level_on", {26'h0, gs[5:0]}, {26'h0, lvl_set[5:0]});
		cmp("level_rest", 32'h0, lvl_set[37:6] | {22'h0, lvl_set[47:38]});
		wb(8'h18, 1'b1, 32'h0);
		wt(4);
		cmp("level_off", 32'h0, lvl_set[31:0] | lvl_set[47:32]);
		pin <= 1'b1;
		wt(4);
		pin <= 1'b0;
		wt(20);
		cmp("upd_seen", 32'h1, {31'h0, upd_count != 16'h0});
		wt(6);
		for (int i = 0; i < 10 && rd_valid !== 1'b1; i++) @(posedge ref_clk);
		cmp("rd_half", 32'hA5A5, {16'h0, rd_half});
		a = wr_full;
		@(posedge ref_clk);
		b = wr_full;
		cmp("wr_pair", 32'h1, {31'h0, (a ^ b) == 8'h66 && (a == 8'h5A || a == 8'h3C)});
		wb(8'h00, 1'b1, 32'h0000_0100);
		wt(6);
		a = {7'h0, rd_valid};
		@(posedge ref_clk);
		cmp("bypass_valid", 32'h3, {30'h0, rd_valid, a[0]});
		print_verdict;
	end
endmodule // spd_top_test
`default_nettype wire
